/* File: rtl/adsq_pkg.sv */
// Package for the converter sequencer: constants, states and carriers
package adsq_pkg;
  localparam int unsigned RES_W      = 8;
  localparam int unsigned CHAN_N     = 8;
  localparam int unsigned CHAN_W     = 3;
  localparam int unsigned SAMPLE_CYC = 4;
  localparam int unsigned BIT_CYC    = 3;
  localparam logic [RES_W-1:0]  RESULT_RST = 8'h00;
  localparam logic [CHAN_W-1:0] CHAN_RST   = 3'h0;
  localparam logic [RES_W-1:0]  TRIAL_MSB  = 8'h80;

  typedef enum logic [1:0] {
    ADSQ_IDLE   = 2'b00,
    ADSQ_SAMPLE = 2'b01,
    ADSQ_SAR    = 2'b10
  } adsq_state_e;

  typedef struct packed {
    logic              enable;
    logic              sw_start;
    logic [CHAN_W-1:0] channel;
  } adsq_mode_s;
endpackage : adsq_pkg

/* File: rtl/adsq_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module adsq_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = ce_in ? d_in : meta_r;
    q_nxt    = ce_in ? meta_r : q_r;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q_out = q_r;
endmodule : adsq_sync
`default_nettype wire

/* File: rtl/adsq_ctrl.sv */
// Successive-approximation converter sequencer with hardware and software start
`timescale 1ns/1ps
`default_nettype none
module adsq_ctrl
  import adsq_pkg::*;
(
  input  wire logic                           clk_in,
  input  wire logic                           rst_in,
  input  wire logic                           ce_in,
  input  wire adsq_pkg::adsq_mode_s           mode_in,
  input  wire logic                           mode_wr_in,
  input  wire logic                           start_trigger_pin_in,
  input  wire logic                           cmp_in,
  output logic [adsq_pkg::CHAN_W-1:0]         chan_sel_out,
  output logic                                sample_out,
  output logic [adsq_pkg::RES_W-1:0]          dac_code_out,
  output logic [adsq_pkg::RES_W-1:0]          conversion_result_reg_out,
  output logic                                conversion_done_irq_out,
  output logic                                busy_out
);
  import adsq_pkg::*;

  logic [1:0]  pins_sync;
  logic        trig_s;
  logic        cmp_s;
  logic        trig_d_r;
  logic        trig_d_nxt;

  // Comparator is treated as asynchronous to the clock
  adsq_sync #(.W(2)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .d_in   ({start_trigger_pin_in, cmp_in}),
    .q_out  (pins_sync)
  );
  assign trig_s = pins_sync[1];
  assign cmp_s  = pins_sync[0];

  adsq_mode_s        mode_r;
  adsq_mode_s        mode_nxt;
  adsq_state_e       st_r;
  adsq_state_e       st_nxt;
  logic [RES_W-1:0]  trial_r;
  logic [RES_W-1:0]  trial_nxt;
  logic [RES_W-1:0]  bit_r;
  logic [RES_W-1:0]  bit_nxt;
  logic [2:0]        cnt_r;
  logic [2:0]        cnt_nxt;
  logic [RES_W-1:0]  result_r;
  logic [RES_W-1:0]  result_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic              repeat_r;
  logic              repeat_nxt;
  logic              hw_edge;
  logic              sw_go;
  logic              hw_go;
  logic              abort;
  logic              conv_done;
  logic              conv_start;
  logic [CHAN_W-1:0] chan_r;
  logic [CHAN_W-1:0] chan_nxt;
  logic [RES_W-1:0]  settled;

  assign hw_edge = trig_s & ~trig_d_r;
  assign sw_go   = mode_wr_in & mode_in.enable & mode_in.sw_start;
  assign hw_go   = mode_r.enable & ~mode_r.sw_start & hw_edge;
  // A write that clears enable beats any start in the same cycle
  assign abort   = mode_wr_in & ~mode_in.enable;
  // Comparator high means input at or above the trial, so the bit stays
  // Comparator low drops the bit under test
  assign settled = cmp_s ? trial_r : (trial_r & ~bit_r);

  // Converter mode register, written whole by one strobe
  always_comb begin
    mode_nxt = mode_wr_in ? mode_in : mode_r;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_r <= '{enable: 1'b0, sw_start: 1'b0, channel: CHAN_RST};
    end else if (ce_in) begin
      mode_r <= mode_nxt;
    end
  end

  // Trigger edge detect; pin idles low, so no false edge after reset
  always_comb begin
    trig_d_nxt = trig_s;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      trig_d_r <= 1'b0;
    end else if (ce_in) begin
      trig_d_r <= trig_d_nxt;
    end
  end

  // Sequencer: sampling phase, then one trial per bit, MSB first
  always_comb begin
    st_nxt     = st_r;
    trial_nxt  = trial_r;
    bit_nxt    = bit_r;
    cnt_nxt    = cnt_r;
    repeat_nxt = repeat_r;
    conv_done  = 1'b0;
    conv_start = 1'b0;
    case (st_r)
      ADSQ_IDLE: begin
        if (sw_go) begin
          st_nxt     = ADSQ_SAMPLE;
          repeat_nxt = 1'b1;
          cnt_nxt    = '0;
          conv_start = 1'b1;
        end else if (hw_go) begin
          st_nxt     = ADSQ_SAMPLE;
          repeat_nxt = 1'b0;
          cnt_nxt    = '0;
          conv_start = 1'b1;
        end
      end
      ADSQ_SAMPLE: begin
        if (cnt_r == 3'(SAMPLE_CYC - 1)) begin
          st_nxt    = ADSQ_SAR;
          trial_nxt = TRIAL_MSB;
          bit_nxt   = TRIAL_MSB;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      ADSQ_SAR: begin
        // Three cycles per bit so the synchronised comparator sees the new code
        if (cnt_r == 3'(BIT_CYC - 1)) begin
          cnt_nxt   = '0;
          bit_nxt   = bit_r >> 1;
          if (bit_r[0]) begin
            conv_done = 1'b1;
            trial_nxt = '0;
            if (repeat_r && mode_r.enable && mode_r.sw_start) begin
              st_nxt     = ADSQ_SAMPLE;
              conv_start = 1'b1;
            end else begin
              st_nxt = ADSQ_IDLE;
            end
          end else begin
            trial_nxt = settled | (bit_r >> 1);
          end
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      default: st_nxt = ADSQ_IDLE;
    endcase
    // Clearing enable aborts; result keeps the last complete value
    if (abort) begin
      st_nxt     = ADSQ_IDLE;
      trial_nxt  = '0;
      conv_start = 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r     <= ADSQ_IDLE;
      trial_r  <= '0;
      bit_r    <= '0;
      cnt_r    <= '0;
      repeat_r <= 1'b0;
    end else if (ce_in) begin
      st_r     <= st_nxt;
      trial_r  <= trial_nxt;
      bit_r    <= bit_nxt;
      cnt_r    <= cnt_nxt;
      repeat_r <= repeat_nxt;
    end
  end

  // Channel held for the whole conversion; a write mid-way waits for the next start
  always_comb begin
    chan_nxt = chan_r;
    if (conv_start) begin
      chan_nxt = mode_nxt.channel;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chan_r <= CHAN_RST;
    end else if (ce_in) begin
      chan_r <= chan_nxt;
    end
  end

  // Result and completion pulse land on the same edge
  // Hardware starts give no pulse; only software repeats ask for service
  always_comb begin
    result_nxt = conv_done ? settled : result_r;
    irq_nxt    = conv_done & repeat_r;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_r <= RESULT_RST;
      irq_r    <= 1'b0;
    end else if (ce_in) begin
      result_r <= result_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign chan_sel_out              = chan_r;
  assign sample_out                = (st_r == ADSQ_SAMPLE);
  assign dac_code_out              = trial_r;
  assign conversion_result_reg_out = result_r;
  assign conversion_done_irq_out   = irq_r;
  assign busy_out                  = (st_r != ADSQ_IDLE);
endmodule : adsq_ctrl
`default_nettype wire

/* File: dv/adsq_asserts.sv */
// Property checks on the converter sequencer ports
`timescale 1ns/1ps
`default_nettype none
module adsq_asserts
  import adsq_pkg::*;
(
  input wire logic            clk_in,
  input wire logic            rst_in,
  input wire logic            ce_in,
  input wire logic            mode_wr_in,
  input wire logic            start_trigger_pin_in,
  input wire logic            cmp_in,
  input wire adsq_mode_s      mode_in,
  input wire logic [2:0]      chan_sel_out,
  input wire logic            sample_out,
  input wire logic            conversion_done_irq_out,
  input wire logic            busy_out,
  input wire logic [7:0]      dac_code_out,
  input wire logic [7:0]      conversion_result_reg_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence go_s; $rose(busy_out); endsequence
  sequence quiet_s; (!start_trigger_pin_in && !mode_wr_in)[*4] ##0 !busy_out; endsequence
  res_hold_a: assert property (!$stable(conversion_result_reg_out) |->
    ##[0:1] (conversion_done_irq_out || !busy_out)) else $error("result moved mid conversion");
  irq_pulse_a: assert property (conversion_done_irq_out |=>
    !conversion_done_irq_out) else $error("irq longer than one cycle");
  sample_len_a: assert property ($rose(sample_out) |->
    sample_out[*4] ##1 !sample_out) else $error("sample phase length");
  sw_go_a: assert property (mode_wr_in && mode_in.enable && mode_in.sw_start && !busy_out
    |=> busy_out && sample_out) else $error("software start not taken");
  idle_stay_a: assert property (quiet_s |=> !busy_out) else $error("start with no cause");
  first_trial_a: assert property (go_s |-> ##4 dac_code_out == TRIAL_MSB)
    else $error("first trial code");
  conv_len_a: assert property (go_s |-> ##[25:30] (conversion_done_irq_out || !busy_out))
    else $error("conversion length");
  resample_next_a: assert property (conversion_done_irq_out ##1 busy_out |-> sample_out)
    else $error("no resample after done");
endmodule : adsq_asserts
bind adsq_ctrl adsq_asserts u_adsq_asserts (.*);
`default_nettype wire

/* File: dv/adsq_analog.sv */
// Analog channel levels and comparator facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module adsq_analog (
  input  wire logic [63:0] lvl_in,
  input  wire logic [2:0]  chan_in,
  input  wire logic [7:0]  dac_in,
  output logic             cmp_out
);
  // Only the selected channel reaches the comparator
  assign cmp_out = lvl_in[chan_in*8 +: 8] >= dac_in;
endmodule : adsq_analog
`default_nettype wire

/* File: dv/adsq_ctrl_tb_top.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module adsq_ctrl_tb_top;
  import adsq_pkg::*;
  logic       clk_in = 0, rst_in = 1, wr = 0, pin = 0;
  adsq_mode_s mode = '0;
  logic [63:0] lvl = '0;
  logic       cmp, smp, irq, busy;
  logic [2:0] chan;
  logic [7:0] dac, res;
  int         err_total = 0, n_checks = 0, irqs = 0, cyc = 0;
  adsq_ctrl u_adsq_ctrl (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .mode_in(mode),
    .mode_wr_in(wr), .start_trigger_pin_in(pin), .cmp_in(cmp), .chan_sel_out(chan),
    .sample_out(smp), .dac_code_out(dac), .conversion_result_reg_out(res),
    .conversion_done_irq_out(irq), .busy_out(busy));
  adsq_analog u_adsq_analog (.lvl_in(lvl), .chan_in(chan), .dac_in(dac), .cmp_out(cmp));
  initial forever #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    irqs <= irqs + int'(irq === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_mode(input logic e, s, input logic [2:0] c);
    @(negedge clk_in); mode = '{e, s, c}; wr = 1;
    @(negedge clk_in); wr = 0;
  endtask : wr_mode
  // Bit-serial trial against a >= comparator
  function automatic logic [7:0] sar(input logic [7:0] v);
    logic [7:0] t;
    t = 0;
    for (int b = 7; b >= 0; b--) if (v >= (t | (8'h01 << b))) t |= 8'h01 << b;
    return t;
  endfunction : sar
  task automatic complete_run;
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(32'h74bb14ef));
    repeat (20) @(negedge clk_in);
    rst_in = 0;
    for (int c = 0; c < 8; c++) begin
      lvl[c*8 +: 8] = (c == 0) ? 8'h00 : (c == 7) ? 8'hff : 8'($urandom);
      wr_mode(1, 0, 3'(c));
      pin = 1;
      repeat (4) @(negedge clk_in);
      pin = 0;
      for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clk_in);
      chk(res, sar(lvl[c*8 +: 8]));
      chk({5'h0, chan}, 8'(c));
      repeat (8) @(negedge clk_in);
      chk({7'h0, busy}, 8'h00);
    end
    chk(8'(irqs), 8'h00);
    lvl[47:40] = 8'($urandom);
    wr_mode(1, 1, 3'd5);
    chk({7'h0, busy}, 8'h01);
    repeat (3) begin
      for (int i = 0; i < 60 && irq !== 1'b1; i++) @(negedge clk_in);
      chk(res, sar(lvl[47:40]));
      @(negedge clk_in);
      lvl[47:40] = 8'($urandom);
    end
    wr_mode(1, 0, 3'd5);
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clk_in);
    // Last pulse is counted one edge after busy drops
    @(negedge clk_in);
    chk(8'(irqs), 8'h04);
    chk(res, sar(lvl[47:40]));
    // Abort mid-conversion, then a trigger while disabled
    lvl[23:16] = 8'($urandom);
    wr_mode(1, 1, 3'd2);
    repeat (10) @(negedge clk_in);
    wr_mode(0, 0, 3'd2);
    chk({7'h0, busy}, 8'h00);
    pin = 1;
    repeat (4) @(negedge clk_in);
    pin = 0;
    repeat (40) @(negedge clk_in);
    chk({7'h0, busy}, 8'h00);
    chk(res, sar(lvl[47:40]));
    chk(8'(irqs), 8'h04);
    complete_run();
  end
endmodule : adsq_ctrl_tb_top
`default_nettype wire
